// >>> rtl/arr_regs.sv
// Range select, alarm status and alarm limit register bank
// What this block does
// - Four-bit span field resets to zero; codes 0-4 pick bipolar spans.
// - Codes with top bit set pick unipolar spans; stored exactly as written.
// - Bit 6 of the range register turns the on-chip reference off; resets 0.
// - Reserved bits of range, status and upper-limit registers read zero.
// - Status bits 15 and 14 show present supply low and supply high.
// - Status bits 11 and 10 show present input low and input high.
// - Status bits 7 and 6 show latched supply low and supply high.
// - Status bits 5 and 4 show latched input low and input high.
// - Status bit 0 is the OR of the four latched flags.
// - A flag reads one while its condition holds; all flags reset to zero.
// - Upper-limit register bits 15-0 hold the upper limit, reset FFFF.
// - Bits 31-24 are writable, reset zero; all eight bits give hysteresis.
// - Status register sits at byte address 20h.
// - Upper limit and hysteresis register sits at byte address 24h.
// - Status holds both present and latched flags for input and supply.
// - Range register sits at byte address 14h.
// - Lower limit register at 28h holds sixteen writable bits, reset zero.
`timescale 1ns/1ps
module arr_regs
  import arr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [DATA_W-1:0] rdData,
  // Conversion results and supply monitor
  input wire logic sampleValid,
  input wire logic [15:0] sample,
  input wire logic supplyLowIn,
  input wire logic supplyHighIn,
  // Configuration to the converter
  output logic [3:0] spanSelect,
  output logic onchipRefOff
);

  // ==========================================================
  // Decode
  arr_bus_req_t req;
  logic hitRange;
  logic hitStatus;
  logic hitUpper;
  logic hitLower;

  assign req = '{addr, wrData, wrStb, rdStb};
  assign hitRange = (req.addr == OFFS_RANGE);
  assign hitStatus = (req.addr == OFFS_STATUS);
  assign hitUpper = (req.addr == OFFS_UPPER);
  assign hitLower = (req.addr == OFFS_LOWER);

  // ==========================================================
  // Range register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spanSelect <= RST_RANGE_SEL;
      onchipRefOff <= RST_REF_OFF;
    end else if (req.wrStb && hitRange) begin
      spanSelect <= req.wrData[3:0];
      onchipRefOff <= req.wrData[POS_REF_OFF];
    end
  end

  // ==========================================================
  // Limit registers
  logic [15:0] upperLimit;
  logic [7:0] inputHysteresis;
  logic [15:0] lowerLimit;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      upperLimit <= RST_UPPER;
      inputHysteresis <= RST_HYST;
    end else if (req.wrStb && hitUpper) begin
      upperLimit <= req.wrData[15:0];
      inputHysteresis <= req.wrData[POS_HYST_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lowerLimit <= RST_LOWER;
    end else if (req.wrStb && hitLower) begin
      lowerLimit <= req.wrData[15:0];
    end
  end

  // ==========================================================
  // Present alarm flags
  arr_alarm_t active;
  logic inHighNow;
  logic inLowNow;

  // Hysteresis byte is used whole; its low bits are zero by software discipline
  arr_hyst_cmp u_cmp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sampleValid(sampleValid),
    .sample(sample),
    .upperLimit(upperLimit),
    .lowerLimit(lowerLimit),
    .hysteresis(inputHysteresis),
    .inputHigh(inHighNow),
    .inputLow(inLowNow)
  );

  logic supLowNow;
  logic supHighNow;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      supLowNow <= 1'b0;
      supHighNow <= 1'b0;
    end else begin
      supLowNow <= supplyLowIn;
      supHighNow <= supplyHighIn;
    end
  end

  assign active = '{supLowNow, supHighNow, inLowNow, inHighNow};

  // ==========================================================
  // Latched alarm flags
  arr_alarm_t latched;
  logic statusRead;

  assign statusRead = req.rdStb && hitStatus;

  arr_trip_latch u_latch (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .active(active),
    .clearAll(statusRead),
    .latched(latched)
  );

  // ==========================================================
  // Read data
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] next_rdData;

  always_comb begin
    statusWord = '0;
    statusWord[POS_SUP_LOW_NOW] = active.supplyLow;
    statusWord[POS_SUP_HIGH_NOW] = active.supplyHigh;
    statusWord[POS_IN_LOW_NOW] = active.inputLow;
    statusWord[POS_IN_HIGH_NOW] = active.inputHigh;
    statusWord[POS_SUP_LOW_LAT] = latched.supplyLow;
    statusWord[POS_SUP_HIGH_LAT] = latched.supplyHigh;
    statusWord[POS_IN_LOW_LAT] = latched.inputLow;
    statusWord[POS_IN_HIGH_LAT] = latched.inputHigh;
    statusWord[POS_ANY_LAT] = |latched;
  end

  always_comb begin
    next_rdData = '0;
    if (hitRange) begin
      next_rdData[3:0] = spanSelect;
      next_rdData[POS_REF_OFF] = onchipRefOff;
    end else if (hitStatus) begin
      next_rdData = statusWord;
    end else if (hitUpper) begin
      next_rdData[15:0] = upperLimit;
      next_rdData[POS_HYST_LSB +: 8] = inputHysteresis;
    end else if (hitLower) begin
      next_rdData[15:0] = lowerLimit;
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData <= RST_RDATA;
    end else if (req.rdStb) begin
      rdData <= next_rdData;
    end else begin
      rdData <= RST_RDATA;
    end
  end

  // ==========================================================
  // Checks
  sequence s_range_write;
    wrStb && hitRange;
  endsequence

  sequence s_status_read;
    rdStb && hitStatus;
  endsequence

  sequence s_upper_write;
    wrStb && hitUpper;
  endsequence

  sequence s_upper_read;
    rdStb && hitUpper;
  endsequence

  sequence s_lower_read;
    rdStb && hitLower;
  endsequence

  sequence s_unmapped_read;
    rdStb && !(hitRange || hitStatus || hitUpper || hitLower);
  endsequence

  a_span_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_range_write |=> spanSelect == $past(wrData[3:0]))
    else $error("span select not written");

  a_ref_off_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_range_write |=> onchipRefOff == $past(wrData[6]))
    else $error("reference disable not written");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    rdStb && (hitRange || hitStatus) |=> rdData[31:16] == 16'h0000 && rdData[9:8] == 2'b00)
    else $error("reserved bits read nonzero");

  a_supply_now: assert property (@(posedge clk_sys) disable iff (!rstn)
    supplyLowIn ##1 s_status_read |=> rdData[POS_SUP_LOW_NOW])
    else $error("supply low not shown");

  a_any_latched: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_status_read |=> rdData[0] == |rdData[7:4])
    else $error("summary flag mismatch");

  a_trip_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    latched.inputHigh && !statusRead |=> latched.inputHigh)
    else $error("latched flag dropped without read");

  a_trip_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_status_read ##0 (active == ALARM_NONE) |=> latched == ALARM_NONE)
    else $error("latched flags not cleared by read");

  a_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_status_read ##0 active.supplyLow |=> latched.supplyLow)
    else $error("set lost against clear");

  a_upper_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_upper_write |=> upperLimit == $past(wrData[15:0]) && inputHysteresis == $past(wrData[31:24]))
    else $error("upper limit not written");

  a_input_high_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleValid && !inHighNow && (sample > upperLimit) |=> inHighNow ##1 latched.inputHigh)
    else $error("input high alarm not raised");

  a_input_low_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleValid && !inLowNow && (sample < lowerLimit) |=> inLowNow)
    else $error("input low alarm not raised");

  a_lower_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrStb && hitLower |=> lowerLimit == $past(wrData[15:0]))
    else $error("lower limit not written");

  a_upper_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_upper_read |=> rdData[23:16] == 8'h00)
    else $error("upper limit reserved bits nonzero");

  a_lower_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_lower_read |=> rdData[31:16] == 16'h0000)
    else $error("lower limit reserved bits nonzero");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_unmapped_read |=> rdData == RST_RDATA)
    else $error("unmapped read nonzero");

  a_idle_rdata: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rdStb |=> rdData == RST_RDATA)
    else $error("read data left standing");

  a_supply_high_now: assert property (@(posedge clk_sys) disable iff (!rstn)
    supplyHighIn |=> active.supplyHigh)
    else $error("supply high not followed");

  a_in_high_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleValid && inHighNow && (upperLimit >= {8'h00, inputHysteresis}) &&
    (sample < upperLimit - {8'h00, inputHysteresis}) |=> !inHighNow)
    else $error("input high alarm not released");

  a_in_low_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleValid && inLowNow &&
    ({1'b0, sample} > ({1'b0, lowerLimit} + {9'h000, inputHysteresis})) |=> !inLowNow)
    else $error("input low alarm not released");

  a_cmp_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !sampleValid |=> $stable(inHighNow) && $stable(inLowNow))
    else $error("input alarm moved without sample");

  a_span_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(wrStb && hitRange) |=> $stable(spanSelect) && $stable(onchipRefOff))
    else $error("range register moved without write");

  a_limit_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(wrStb && hitUpper) |=> $stable(upperLimit) && $stable(inputHysteresis))
    else $error("upper limit moved without write");

  a_latch_in_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    active.inputLow |=> latched.inputLow)
    else $error("input low not latched");

  a_latch_sup_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    active.supplyHigh |=> latched.supplyHigh)
    else $error("supply high not latched");

  a_any_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_status_read ##0 (latched == ALARM_NONE) |=> !rdData[POS_ANY_LAT])
    else $error("summary flag set with no latched alarm");

endmodule : arr_regs

// >>> rtl/arr_pkg.sv
// Shared constants and types for the converter range and alarm registers
package arr_pkg;

  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFFS_RANGE = 8'h14;
  localparam logic [7:0] OFFS_STATUS = 8'h20;
  localparam logic [7:0] OFFS_UPPER = 8'h24;
  localparam logic [7:0] OFFS_LOWER = 8'h28;

  // ==========================================================
  // Field positions
  localparam int POS_REF_OFF = 6;
  localparam int POS_SUP_LOW_NOW = 15;
  localparam int POS_SUP_HIGH_NOW = 14;
  localparam int POS_IN_LOW_NOW = 11;
  localparam int POS_IN_HIGH_NOW = 10;
  localparam int POS_SUP_LOW_LAT = 7;
  localparam int POS_SUP_HIGH_LAT = 6;
  localparam int POS_IN_LOW_LAT = 5;
  localparam int POS_IN_HIGH_LAT = 4;
  localparam int POS_ANY_LAT = 0;
  localparam int POS_HYST_LSB = 24;

  // ==========================================================
  // Reset values
  localparam logic [3:0] RST_RANGE_SEL = 4'h0;
  localparam logic RST_REF_OFF = 1'b0;
  localparam logic [15:0] RST_UPPER = 16'hFFFF;
  localparam logic [7:0] RST_HYST = 8'h00;
  localparam logic [15:0] RST_LOWER = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic supplyLow;
    logic supplyHigh;
    logic inputLow;
    logic inputHigh;
  } arr_alarm_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrStb;
    logic rdStb;
  } arr_bus_req_t;

  localparam arr_alarm_t ALARM_NONE = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : arr_pkg

// >>> rtl/arr_hyst_cmp.sv
// Input alarm comparator with hysteresis on release
`timescale 1ns/1ps
module arr_hyst_cmp
  import arr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Conversion results
  input wire logic sampleValid,
  input wire logic [15:0] sample,
  // Limits
  input wire logic [15:0] upperLimit,
  input wire logic [15:0] lowerLimit,
  input wire logic [7:0] hysteresis,
  // Present comparison state
  output logic inputHigh,
  output logic inputLow
);

  logic [16:0] lowerRelease;
  logic releaseHigh;
  logic releaseLow;
  logic next_inputHigh;
  logic next_inputLow;

  // Release points sit one hysteresis step inside each limit
  assign lowerRelease = {1'b0, lowerLimit} + {9'h000, hysteresis};
  assign releaseHigh = (upperLimit >= {8'h00, hysteresis}) && (sample < (upperLimit - {8'h00, hysteresis}));
  assign releaseLow = {1'b0, sample} > lowerRelease;

  always_comb begin
    next_inputHigh = inputHigh ? !releaseHigh : (sample > upperLimit);
    next_inputLow = inputLow ? !releaseLow : (sample < lowerLimit);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      inputHigh <= 1'b0;
      inputLow <= 1'b0;
    end else if (sampleValid) begin
      inputHigh <= next_inputHigh;
      inputLow <= next_inputLow;
    end
  end

endmodule : arr_hyst_cmp

// >>> rtl/arr_trip_latch.sv
// Sticky alarm flags, cleared by a status read
`timescale 1ns/1ps
module arr_trip_latch
  import arr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Events and clear
  input wire arr_alarm_t active,
  input wire logic clearAll,
  // Latched flags
  output arr_alarm_t latched
);

  logic [3:0] setVec;
  logic [3:0] flagVec;

  assign setVec = active;
  assign latched = flagVec;

  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        flagVec[i] <= 1'b0;
      end else if (setVec[i]) begin
        flagVec[i] <= 1'b1;
      end else if (clearAll) begin
        flagVec[i] <= 1'b0;
      end
    end
  end

endmodule : arr_trip_latch

// >>> testbench/arr_regs_tb.sv
// Self-checking bench for the range and alarm register bank
`timescale 1ns/1ps
module arr_regs_tb;
  import arr_pkg::*;

  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic sampleValid = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic supplyLowIn = 1'b0;
  logic supplyHighIn = 1'b0;
  logic [3:0] spanSelect;
  logic onchipRefOff;
  int errTotal = 0;
  int checked = 0;
  int cycles = 0;
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};

  always #2.5 clk_sys = ~clk_sys;

  arr_regs i_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .addr(addr),
    .wrData(wrData),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .rdData(rdData),
    .sampleValid(sampleValid),
    .sample(sample),
    .supplyLowIn(supplyLowIn),
    .supplyHighIn(supplyHighIn),
    .spanSelect(spanSelect),
    .onchipRefOff(onchipRefOff)
  );

  // ==========================================================
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Register port access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk_sys);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    @(negedge clk_sys);
    chk(what, rdData, exp);
  endtask : rd

  task automatic put_sample(input logic [15:0] v);
    @(posedge clk_sys);
    sample <= v;
    sampleValid <= 1'b1;
    @(posedge clk_sys);
    sampleValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : put_sample

  task automatic supply(input logic lo, input logic hi);
    @(posedge clk_sys);
    supplyLowIn <= lo;
    supplyHighIn <= hi;
    repeat (4) @(posedge clk_sys);
  endtask : supply

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk("spanSelect reset", {28'h000_0000, spanSelect}, 32'h0000_0000);
    chk("onchipRefOff reset", {31'h0000_0000, onchipRefOff}, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000, "range reset");
    rd(8'h20, 32'h0000_0000, "status reset");
    rd(8'h24, 32'h0000_FFFF, "upper reset");
    rd(8'h28, 32'h0000_0000, "lower reset");
    @(negedge clk_sys);
    chk("rdData after read", rdData, 32'h0000_0000);
    // Every listed span code, stored and driven out
    foreach (codes[i]) begin
      wr(8'h14, {28'h000_0000, codes[i]});
      @(negedge clk_sys);
      chk("spanSelect", {28'h000_0000, spanSelect}, {28'h000_0000, codes[i]});
    end
    wr(8'h14, 32'hFFFF_FFFF);
    @(negedge clk_sys);
    chk("onchipRefOff set", {31'h0000_0000, onchipRefOff}, 32'h0000_0001);
    rd(8'h14, 32'h0000_004F, "range reserved");
    wr(8'h24, 32'hFCFF_FFFF);
    rd(8'h24, 32'hFC00_FFFF, "upper reserved");
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28, 32'h0000_FFFF, "lower reserved");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, "status write ignored");
    rd(8'h21, 32'h0000_0000, "status byte alias");
    rd(8'h30, 32'h0000_0000, "unmapped read");
    // Supply low held: set wins over the clear of a read
    supply(1'b1, 1'b0);
    rd(8'h20, 32'h0000_8081, "supply low held");
    rd(8'h20, 32'h0000_8081, "supply low set wins");
    supply(1'b0, 1'b0);
    rd(8'h20, 32'h0000_0081, "supply low latched");
    rd(8'h20, 32'h0000_0000, "supply low cleared");
    supply(1'b0, 1'b1);
    supply(1'b0, 1'b0);
    rd(8'h20, 32'h0000_0041, "supply high latched");
    rd(8'h20, 32'h0000_0000, "supply high cleared");
    // Input high with hysteresis 4, low two bits kept zero
    wr(8'h24, 32'h0400_1000);
    wr(8'h28, 32'h0000_0000);
    put_sample(16'h1000);
    rd(8'h20, 32'h0000_0000, "input at upper limit");
    put_sample(16'h1001);
    rd(8'h20, 32'h0000_0411, "input high");
    put_sample(16'h0FFC);
    rd(8'h20, 32'h0000_0411, "input high hysteresis");
    put_sample(16'h0FFB);
    rd(8'h20, 32'h0000_0011, "input high released");
    // Input low with the same hysteresis
    wr(8'h28, 32'h0000_0100);
    put_sample(16'h00FF);
    rd(8'h20, 32'h0000_0821, "input low");
    put_sample(16'h0104);
    rd(8'h20, 32'h0000_0821, "input low hysteresis");
    put_sample(16'h0105);
    rd(8'h20, 32'h0000_0021, "input low released");
    rd(8'h20, 32'h0000_0000, "input low cleared");
    // Reset in mid-run restores every value
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h14, 32'h0000_0000, "range after reset");
    rd(8'h24, 32'h0000_FFFF, "upper after reset");
    rd(8'h28, 32'h0000_0000, "lower after reset");
    report_and_stop();
  end

endmodule : arr_regs_tb
